// >>> rtl/debounce_timer.sv
// Debounce timer: counts while its condition holds and flags expiry of the limit.
// Assumes the condition is already synchronised to clock.
`timescale 1ns/1ps
module debounce_timer
   import prot_seq_pkg::*;
(
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic active,
   input  wire tmr_t limit,
   output logic      expired
);

   typedef struct packed {
      tmr_t count;
      logic done;
   } dbt_state_t;

   dbt_state_t st_reg;
   dbt_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (!active) begin
         st_next.count = '0;
         st_next.done  = 1'b0;
      end else if (!st_reg.done) begin
         st_next.count = tmr_t'(st_reg.count + 1'b1);
         // Compare with >= so a limit that shrinks mid-count still expires at once.
         if (st_next.count >= limit) begin
            st_next.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign expired = st_reg.done;

endmodule

// >>> rtl/prot_seq_pkg.sv
// Package for the PWM stage protection sequencer: timing, register map and carrier types.
// Assumes a single 40 MHz clock and comparator flags that arrive asynchronously.
package prot_seq_pkg;

   // Clock and documented times, each in its own unit.
   localparam int CLK_PERIOD_NS  = 25;
   localparam int TRIG_FAST_US   = 110;
   localparam int TRIG_SLOW_MS   = 10;
   localparam int OLP_MS         = 50;
   localparam int BLANK_NS       = 1500;

   // Least times round up to whole cycles.
   localparam int TRIG_FAST_CYC  = (TRIG_FAST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRIG_SLOW_CYC  = (TRIG_SLOW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OLP_CYC        = (OLP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_CYC      = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int TMR_W          = 21;
   localparam int BLANK_W        = 8;
   typedef logic [TMR_W-1:0]   tmr_t;
   typedef logic [BLANK_W-1:0] blank_t;

   // Register bus and map.
   localparam int ADDR_W         = 5;
   localparam int DATA_W         = 32;
   localparam logic [ADDR_W-1:0] CTRL_OFS     = 5'h00;
   localparam logic [ADDR_W-1:0] STATE_OFS    = 5'h04;
   localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 5'h08;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 5'h0C;
   localparam logic [ADDR_W-1:0] CAUSE_OFS    = 5'h10;

   localparam logic CTRL_RESET   = 1'h1;

   // Event bit positions, shared by interrupt status, mask and cause registers.
   localparam int EV_VDD_OVP     = 0;
   localparam int EV_TRIG        = 1;
   localparam int EV_OUT_OVP     = 2;
   localparam int EV_FB_OLP      = 3;
   localparam int EV_UVLO        = 4;
   localparam int EV_START       = 5;
   localparam int EV_W           = 6;
   typedef logic [EV_W-1:0] ev_t;

   typedef enum logic [1:0] {
      ST_OFF  = 2'h0,
      ST_RUN  = 2'h1,
      ST_PROT = 2'h3
   } seq_state_t;

   // Comparator and gate flags from the analog side.
   typedef struct packed {
      logic supply_ovp;
      logic trig_low;
      logic trig_very_low;
      logic aux_over;
      logic fb_over;
      logic supply_on_lvl;
      logic supply_off_lvl;
      logic gate_on;
   } sense_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_t;

   typedef struct packed {
      logic pfc_en;
      logic pwm_en;
      logic hv_startup_en;
      logic aux_power_en;
   } drive_t;

endpackage

// >>> rtl/prot_sequencer.sv
// Protection and supply lockout sequencer for the flyback PWM stage.
// Assumes comparator flags arrive asynchronously and software uses the plain register port.
`timescale 1ns/1ps

// Functional notes
// - Supply over-voltage stops switching, enters protection.
// - Trigger pin under 0.8 V debounced trips protection.
// - Under 0.5 V uses short 110 us debounce.
// - Between 0.5 and 0.8 V uses 10 ms.
// - Sample aux sense only after off blanking.
// - Sampled aux over 2.5 V trips output protection.
// - Aux over-voltage check every switching cycle.
// - Feedback high 50 ms continuous trips overload.
// - Supply lockout hysteresis, on 18 V, off 10 V.
// - Start switching at turn-on if no fault.
// - Below turn-off, halt switching, power down extras.
// - After turn-on, disable high-voltage startup path.
module prot_sequencer
   import prot_seq_pkg::*;
#(
   parameter tmr_t TRIG_FAST_LIMIT = tmr_t'(TRIG_FAST_CYC),
   parameter tmr_t TRIG_SLOW_LIMIT = tmr_t'(TRIG_SLOW_CYC),
   parameter tmr_t OLP_LIMIT       = tmr_t'(OLP_CYC)
)
(
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire sense_t            sense,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic [DATA_W-1:0]      rdata,
   output logic                   irq,
   output logic                   pfc_en,
   output logic                   pwm_en,
   output logic                   hv_startup_en,
   output logic                   aux_power_en,
   output logic                   protect_active
);

   typedef struct packed {
      sense_t           sync1;
      sense_t           sync2;
      logic             gate_d;
      seq_state_t       state;
      logic             lockout_ok;
      blank_t           blank_cnt;
      logic             blanking;
      ev_t              cause;
      ev_t              irq_stat;
      ev_t              irq_mask;
      logic             run_allow;
      logic [DATA_W-1:0] rdata;
      drive_t           drive;
      logic             irq;
      logic             prot;
   } seq_t;

   seq_t     st_reg;
   seq_t     st_next;
   bus_req_t bus;
   tmr_t     trig_limit;
   logic     trig_expired;
   logic     olp_expired;
   logic     trig_active;
   logic     olp_active;

   assign bus.addr  = addr;
   assign bus.wdata = wdata;
   assign bus.wr    = wr;
   assign bus.rd    = rd;

   // The trigger pin owns one timer whose limit follows the depth of the dip, so a
   // slow thermal drift that later falls under 0.5 V still trips on the short limit.
   assign trig_limit  = st_reg.sync2.trig_very_low ? TRIG_FAST_LIMIT : TRIG_SLOW_LIMIT;
   assign trig_active = st_reg.lockout_ok && st_reg.sync2.trig_low;
   assign olp_active  = st_reg.lockout_ok && st_reg.sync2.fb_over;

   debounce_timer u_trig_timer (
      .clock   (clock),
      .reset   (reset),
      .active  (trig_active),
      .limit   (trig_limit),
      .expired (trig_expired)
   );

   debounce_timer u_olp_timer (
      .clock   (clock),
      .reset   (reset),
      .active  (olp_active),
      .limit   (OLP_LIMIT),
      .expired (olp_expired)
   );

   always_comb begin
      ev_t  events;
      ev_t  faults;
      ev_t  w1c;
      logic gate_fall;
      logic aux_sample;
      logic supply_rise;

      st_next     = st_reg;
      events      = '0;
      faults      = '0;
      w1c         = '0;
      gate_fall   = 1'b0;
      aux_sample  = 1'b0;
      supply_rise = 1'b0;

      // Two-stage synchroniser on every analog flag.
      st_next.sync1  = sense;
      st_next.sync2  = st_reg.sync1;
      st_next.gate_d = st_reg.sync2.gate_on;

      // Supply lockout with hysteresis between the two thresholds.
      if (st_reg.sync2.supply_off_lvl) begin
         st_next.lockout_ok = 1'b0;
      end else if (st_reg.sync2.supply_on_lvl) begin
         st_next.lockout_ok = 1'b1;
         supply_rise        = !st_reg.lockout_ok;
      end

      // Off-interval blanking: the gate falling edge starts the count, and the aux
      // comparator is read once when it ends, so leakage ringing is never seen.
      gate_fall = st_reg.gate_d && !st_reg.sync2.gate_on;
      if (st_reg.state != ST_RUN || st_reg.sync2.gate_on) begin
         st_next.blanking  = 1'b0;
         st_next.blank_cnt = '0;
      end else if (gate_fall) begin
         st_next.blanking  = 1'b1;
         st_next.blank_cnt = blank_t'(BLANK_CYC);
      end else if (st_reg.blanking) begin
         st_next.blank_cnt = blank_t'(st_reg.blank_cnt - 1'b1);
         if (st_reg.blank_cnt == blank_t'(1)) begin
            st_next.blanking = 1'b0;
            aux_sample       = 1'b1;
         end
      end

      if (st_reg.lockout_ok) begin
         faults[EV_VDD_OVP] = st_reg.sync2.supply_ovp;
         faults[EV_TRIG]    = trig_expired;
         faults[EV_OUT_OVP] = aux_sample && st_reg.sync2.aux_over;
         faults[EV_FB_OLP]  = olp_expired;
      end

      case (st_reg.state)
         ST_OFF: begin
            if (st_reg.lockout_ok && (faults != '0)) begin
               st_next.state = ST_PROT;
            end else if (st_reg.lockout_ok && st_next.lockout_ok && st_reg.run_allow) begin
               st_next.state     = ST_RUN;
               events[EV_START]  = 1'b1;
            end
         end
         ST_RUN: begin
            // The fresh lockout value is used so the gates drop on the same edge as lockout,
            // never leaving one cycle of switching with the supply already under turn-off.
            if (!st_next.lockout_ok) begin
               st_next.state    = ST_OFF;
               events[EV_UVLO]  = 1'b1;
            end else if (faults != '0) begin
               st_next.state = ST_PROT;
            end else if (!st_reg.run_allow) begin
               st_next.state = ST_OFF;
            end
         end
         ST_PROT: begin
            if (!st_next.lockout_ok) begin
               st_next.state   = ST_OFF;
               events[EV_UVLO] = 1'b1;
            end
         end
         default: begin
            st_next.state = ST_OFF;
         end
      endcase

      // Cause bits record which fault tripped and clear when protection ends.
      if (st_reg.state == ST_PROT && st_next.state == ST_OFF) begin
         st_next.cause = '0;
      end else begin
         st_next.cause = st_reg.cause | faults;
      end
      events = events | faults;
      // A fresh power-up is not an event on its own, but it keeps supply_rise honest.
      if (supply_rise && st_reg.state != ST_OFF) begin
         st_next.state = ST_OFF;
      end

      // Register writes.
      if (bus.wr) begin
         case (bus.addr)
            CTRL_OFS: begin
               st_next.run_allow = bus.wdata[0];
            end
            IRQ_STAT_OFS: begin
               w1c = bus.wdata[EV_W-1:0];
            end
            IRQ_MASK_OFS: begin
               st_next.irq_mask = bus.wdata[EV_W-1:0];
            end
            default: begin
               w1c = '0;
            end
         endcase
      end
      // Set wins over clear so an event in the clearing cycle survives.
      st_next.irq_stat = (st_reg.irq_stat & ~w1c) | events;
      st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

      // Register reads: data stands for the one cycle after the strobe only.
      st_next.rdata = '0;
      if (bus.rd) begin
         case (bus.addr)
            CTRL_OFS: begin
               st_next.rdata = {{(DATA_W-1){1'b0}}, st_reg.run_allow};
            end
            STATE_OFS: begin
               st_next.rdata = {{(DATA_W-12){1'b0}}, st_reg.sync2,
                                st_reg.lockout_ok, st_reg.blanking, st_reg.state};
            end
            IRQ_STAT_OFS: begin
               st_next.rdata = {{(DATA_W-EV_W){1'b0}}, st_reg.irq_stat};
            end
            IRQ_MASK_OFS: begin
               st_next.rdata = {{(DATA_W-EV_W){1'b0}}, st_reg.irq_mask};
            end
            CAUSE_OFS: begin
               st_next.rdata = {{(DATA_W-EV_W){1'b0}}, st_reg.cause};
            end
            default: begin
               st_next.rdata = '0;
            end
         endcase
      end

      // Outputs follow the next state so they change on the same edge as it.
      st_next.drive.pfc_en        = (st_next.state == ST_RUN);
      st_next.drive.pwm_en        = (st_next.state == ST_RUN);
      st_next.drive.hv_startup_en = !st_next.lockout_ok;
      st_next.drive.aux_power_en  = st_next.lockout_ok;
      st_next.prot                = (st_next.state == ST_PROT);
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         st_reg                     <= '0;
         st_reg.state               <= ST_OFF;
         st_reg.run_allow           <= CTRL_RESET;
         st_reg.drive.hv_startup_en <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata          = st_reg.rdata;
   assign irq            = st_reg.irq;
   assign pfc_en         = st_reg.drive.pfc_en;
   assign pwm_en         = st_reg.drive.pwm_en;
   assign hv_startup_en  = st_reg.drive.hv_startup_en;
   assign aux_power_en   = st_reg.drive.aux_power_en;
   assign protect_active = st_reg.prot;

endmodule

// >>> sim/power_stage_model.sv
// Analog front end: turns commanded pin levels in millivolts into comparator flags.
// Assumes the bench drives levels and gate; hysteresis belongs to the sequencer, not here.
`timescale 1ns/1ps
module power_stage_model
   import prot_seq_pkg::*;
#(
   parameter logic [15:0] OVP_MV = 16'h6D60
)
(
   input  wire logic [15:0] vdd_mv,
   input  wire logic [15:0] trig_mv,
   input  wire logic [15:0] aux_mv,
   input  wire logic [15:0] fb_mv,
   input  wire logic        gate,
   output sense_t           sense
);
   // A pulled-down trigger pin reads as both low flags below the fast level.
   assign sense = {vdd_mv > OVP_MV,
                   trig_mv < 16'h0320,
                   trig_mv < 16'h01F4,
                   aux_mv > 16'h09C4,
                   fb_mv > 16'h1068,
                   vdd_mv >= 16'h4650,
                   vdd_mv < 16'h2710,
                   gate};
endmodule

// >>> sim/prot_seq_properties.sv
// Concurrent checks on the protection sequencer ports.
// Assumes one clock domain; bound to the sequencer from the bench top.
`timescale 1ns/1ps
module prot_seq_properties
   import prot_seq_pkg::*;
(
   input wire logic              clock,
   input wire logic              reset,
   input wire sense_t            sense,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic              irq,
   input wire logic              pfc_en,
   input wire logic              pwm_en,
   input wire logic              hv_startup_en,
   input wire logic              aux_power_en,
   input wire logic              protect_active
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_ovp_stop; sense.supply_ovp |-> ##3 !pwm_en && !pfc_en; endproperty
   a_ovp_stop: assert property (p_ovp_stop) else $error("switching after supply ovp");
   property p_ovp_prot; sense.supply_ovp && aux_power_en && !sense.supply_off_lvl |-> ##[1:3] protect_active;
   endproperty
   a_ovp_prot: assert property (p_ovp_prot) else $error("no protection after supply ovp");
   property p_run_ok; pwm_en |-> pfc_en && aux_power_en && !protect_active; endproperty
   a_run_ok: assert property (p_run_ok) else $error("switching outside run");
   property p_hv_pair; hv_startup_en != aux_power_en; endproperty
   a_hv_pair: assert property (p_hv_pair) else $error("startup path and lockout disagree");
   property p_off_halt; sense.supply_off_lvl |-> ##3 !aux_power_en && !pwm_en; endproperty
   a_off_halt: assert property (p_off_halt) else $error("still running below turn-off");
   property p_prot_hold; $fell(protect_active) |-> $past(sense.supply_off_lvl, 3); endproperty
   a_prot_hold: assert property (p_prot_hold) else $error("protection left early");
   property p_on_lvl; $rose(aux_power_en) |-> $past(sense.supply_on_lvl, 3); endproperty
   a_on_lvl: assert property (p_on_lvl) else $error("lockout released without turn-on");
   property p_irq_mask; wr && addr == IRQ_MASK_OFS && wdata[EV_W-1:0] == '0 |-> ##2 !irq; endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
   property p_rd_idle; !rd |=> rdata == '0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule

// >>> sim/tb.sv
// Self-checking bench for the protection sequencer with a comparator front-end model.
// Assumes shortened debounce limits so the whole run stays under a thousand cycles.
`timescale 1ns/1ps
module tb;
   import prot_seq_pkg::*;
   localparam int         FAST = 20;
   localparam int         SLOW = 60;
   localparam int         OLP  = 100;
   localparam logic [4:0] RUN  = 5'h1A;
   localparam logic [4:0] PROT = 5'h06;
   localparam logic [4:0] LOCK = 5'h02;
   localparam logic [4:0] DOWN = 5'h01;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        wr, rd, gate, irq, pfc_en, pwm_en, hv_startup_en, aux_power_en, protect_active;
   logic [4:0]  addr;
   logic [31:0] wdata, rdata;
   logic [15:0] vdd_mv, trig_mv, aux_mv, fb_mv;
   sense_t      sense;
   int          bad_count = 0;
   int          checks_done = 0;
   logic [15:0] lvl [3] = '{16'h0190, 16'h0258, 16'h1130};
   int          lim [3] = '{FAST, SLOW, OLP};

   power_stage_model pm (.vdd_mv(vdd_mv), .trig_mv(trig_mv), .aux_mv(aux_mv), .fb_mv(fb_mv),
      .gate(gate), .sense(sense));
   prot_sequencer #(.TRIG_FAST_LIMIT(tmr_t'(FAST)), .TRIG_SLOW_LIMIT(tmr_t'(SLOW)),
      .OLP_LIMIT(tmr_t'(OLP))) dut (.clock(clock), .reset(reset), .sense(sense), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .pfc_en(pfc_en), .pwm_en(pwm_en),
      .hv_startup_en(hv_startup_en), .aux_power_en(aux_power_en), .protect_active(protect_active));

   initial forever #12.5 clock = ~clock;

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic st(input logic [4:0] e);
      chk({27'h0, pwm_en, pfc_en, protect_active, aux_power_en, hv_startup_en}, {27'h0, e});
   endtask
   // Strobes drop one cycle before the next access so no signal is driven twice in a step.
   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      tick(1);
      wr <= 1'b0;
      tick(1);
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      addr <= a;
      rd <= 1'b1;
      tick(1);
      rd <= 1'b0;
      chk(rdata, e);
      tick(1);
   endtask
   task automatic vdd(input logic [15:0] v);
      vdd_mv <= v;
      tick(5);
   endtask
   task automatic recover();
      vdd(16'h2328);
      vdd(16'h4A38);
      st(RUN);
   endtask
   task automatic pin(input int i, input logic [15:0] v);
      if (i == 2) fb_mv <= v;
      else trig_mv <= v;
   endtask
   task automatic sw(input logic [15:0] early, input logic [15:0] late);
      gate <= 1'b1;
      tick(5);
      gate <= 1'b0;
      aux_mv <= early;
      tick(30);
      aux_mv <= late;
      tick(50);
      aux_mv <= 16'h03E8;
   endtask
   task automatic close_out();
      $display("Checks %0d, errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      tick(20000);
      bad_count++;
      close_out();
   end

   initial begin
      {wr, rd, gate} = 3'h0;
      addr = 5'h00;
      wdata = 32'h0;
      {vdd_mv, aux_mv} = {16'h0000, 16'h03E8};
      {trig_mv, fb_mv} = {16'h07D0, 16'h07D0};
      tick(6);
      st(DOWN);
      reset <= 1'b0;
      tick(1);
      rd_chk(CTRL_OFS, 32'h1);
      rd_chk(IRQ_MASK_OFS, 32'h0);
      vdd(16'h4A38);
      st(RUN);
      rd_chk(STATE_OFS, 32'h49);
      rd_chk(IRQ_STAT_OFS, 32'h20);
      wr_reg(IRQ_STAT_OFS, 32'h20);
      rd_chk(IRQ_STAT_OFS, 32'h0);
      wr_reg(5'h1C, 32'hFFFFFFFF);
      rd_chk(5'h14, 32'h0);
      vdd(16'h36B0);
      st(RUN);
      wr_reg(IRQ_MASK_OFS, 32'h1);
      vdd(16'h7530);
      st(PROT);
      chk({31'h0, irq}, 32'h1);
      rd_chk(CAUSE_OFS, 32'h1);
      rd_chk(STATE_OFS, 32'h84B);
      vdd(16'h4A38);
      st(PROT);
      wr_reg(IRQ_STAT_OFS, 32'h3F);
      chk({31'h0, irq}, 32'h0);
      wr_reg(IRQ_MASK_OFS, 32'h0);
      vdd(16'h2328);
      st(DOWN);
      rd_chk(CAUSE_OFS, 32'h0);
      rd_chk(IRQ_STAT_OFS, 32'h10);
      vdd(16'h36B0);
      st(DOWN);
      vdd(16'h4A38);
      st(RUN);
      foreach (lvl[i]) begin
         pin(i, lvl[i]);
         tick(lim[i] - 5);
         pin(i, 16'h07D0);
         tick(10);
         st(RUN);
         pin(i, lvl[i]);
         tick(lim[i] - 10);
         st(RUN);
         tick(20);
         st(PROT);
         pin(i, 16'h07D0);
         recover();
      end
      sw(16'h0BB8, 16'h03E8);
      st(RUN);
      sw(16'h03E8, 16'h0BB8);
      st(PROT);
      recover();
      wr_reg(CTRL_OFS, 32'h0);
      st(LOCK);
      vdd(16'h2328);
      vdd(16'h4A38);
      st(LOCK);
      wr_reg(CTRL_OFS, 32'h1);
      recover();
      reset <= 1'b1;
      tick(2);
      st(DOWN);
      reset <= 1'b0;
      tick(1);
      rd_chk(CTRL_OFS, 32'h1);
      close_out();
   end
endmodule

bind prot_sequencer prot_seq_properties chk_i (.clock(clock), .reset(reset), .sense(sense),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .pfc_en(pfc_en),
   .pwm_en(pwm_en), .hv_startup_en(hv_startup_en), .aux_power_en(aux_power_en),
   .protect_active(protect_active));
